// ==== verilog/fsp_host.v ====
// host controller: write strobes, status polling, sector protect and unprotect
// Summary of operation
// [R1] toggle status valid after last write edge
// [R2] sector toggle bit flips inside erased sectors
// [R3] progress toggle tells active from suspended
// [R4] host double-reads byte and compares toggles
// [R5] timeout high: retest, fail sends reset
// [R6] interrupted polling restarts with double read
// [R7] timeout flag high marks failed operation
// [R8] after timeout host writes reset command
// [R9] no timeout for non-blank program
// [R10] erase window bit low during acceptance
// [R11] window bit one means commands ignored
// [R12] host checks window bit before and after; erase-add reads it only after the write
// [R13] device powers up in array read
// [R14] strobes shorter than 5ns ignored
// [R15] write only with ce, we low, oe high
// [R16] protect: high voltage, we pulse programs
// [R17] verify reads bit zero for protected sector
// [R18] id mode uses only id select address
// [R19] in-system id read shows protection
// [R20] unprotect: hv on oe and a9, a6 high
// [R21] protect all sectors before unprotect; the host does not do this and leaves it to the caller
// [R22] unprotected sector reads all zeros
`timescale 1ns/1ps
`default_nettype none
`include "fsp_regs.vh"
module fsp_host (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // user command port
  input wire cmd_valid,
  input wire [2:0] cmd_op,
  input wire [18:0] cmd_addr,
  input wire [7:0] cmd_wdata,
  output reg cmd_ready_ff,
  output reg rsp_valid_ff,
  output reg [1:0] rsp_code_ff,
  output reg [7:0] rsp_rdata_ff,
  // flash pins
  output reg [18:0] flash_addr_ff,
  input wire [7:0] flash_dq_in,
  output reg [7:0] flash_dq_out_ff,
  output reg flash_dq_oe_ff,
  output reg flash_ce_n_ff,
  output reg flash_oe_n_ff,
  output reg flash_we_n_ff,
  output reg hv_addr_en_ff,
  output reg hv_oe_en_ff
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_RD = 4'h1;
  localparam [3:0] ST_WR = 4'h2;
  localparam [3:0] ST_WR_GAP = 4'h3;
  localparam [3:0] ST_HV = 4'h4;
  localparam [3:0] ST_HV_END = 4'h5;
  localparam [3:0] ST_RSP = 4'h6;
  localparam [3:0] ST_RST_WR = 4'h7;
  localparam [12:0] READ_CYC = `FSP_READ_CYC;
  localparam [12:0] WPULSE_CYC = `FSP_WPULSE_CYC;
  parameter [12:0] HV_CYC = `FSP_HV_CYC;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  reg rst_s1_ff;
  reg rst_s2_ff;
  wire rst_n = rst_s2_ff;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end

  // data pins come from the device, so synchronise before use
  reg [7:0] dq_s1_ff;
  reg [7:0] dq_s2_ff;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_s1_ff <= 8'h00;
      dq_s2_ff <= 8'h00;
    end else begin
      dq_s1_ff <= flash_dq_in;
      dq_s2_ff <= dq_s1_ff;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  reg [3:0] state_ff;
  reg [12:0] cnt_ff;
  reg [2:0] op_ff;
  reg [1:0] nrd_ff;     // reads done in current poll pass
  reg [7:0] first_ff;   // byte from previous read
  reg to_seen_ff;       // timeout already noted this pass

  // toggle compare of the two status bits
  function toggling;
    input [7:0] a;
    input [7:0] b;
    begin
      toggling = (a[`FSP_BIT_PROGRESS_TOGGLE] != b[`FSP_BIT_PROGRESS_TOGGLE]) ||
                 (a[`FSP_BIT_SECTOR_TOGGLE] != b[`FSP_BIT_SECTOR_TOGGLE]);
    end
  endfunction

  wire [7:0] rd = dq_s2_ff;
  wire cnt_done = (cnt_ff == 13'h0000);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 13'h0000;
      op_ff <= 3'h0;
      nrd_ff <= 2'h0;
      first_ff <= 8'h00;
      to_seen_ff <= 1'b0;
      cmd_ready_ff <= 1'b0;
      rsp_valid_ff <= 1'b0;
      rsp_code_ff <= `FSP_RES_DONE;
      rsp_rdata_ff <= 8'h00;
      flash_addr_ff <= 19'h00000;
      flash_dq_out_ff <= 8'h00;
      flash_dq_oe_ff <= 1'b0;
      flash_ce_n_ff <= 1'b1;
      flash_oe_n_ff <= 1'b1;
      flash_we_n_ff <= 1'b1;
      hv_addr_en_ff <= 1'b0;
      hv_oe_en_ff <= 1'b0;
    end else begin
      rsp_valid_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          cmd_ready_ff <= 1'b1;
          if (cmd_valid && cmd_ready_ff) begin
            cmd_ready_ff <= 1'b0;
            op_ff <= cmd_op;
            flash_addr_ff <= cmd_addr;
            flash_dq_out_ff <= cmd_wdata;
            // [R6] every poll starts fresh
            nrd_ff <= 2'h0;
            to_seen_ff <= 1'b0;
            case (cmd_op)
              `FSP_CMD_WRITE, `FSP_CMD_ERASE_ADD: begin
                // [R15] ce, we low, oe held high
                flash_oe_n_ff <= 1'b1;
                flash_dq_oe_ff <= 1'b1;
                flash_ce_n_ff <= 1'b0;
                flash_we_n_ff <= 1'b0;
                // [R14] pulse far above glitch width
                cnt_ff <= WPULSE_CYC;
                state_ff <= ST_WR;
              end
              `FSP_CMD_PROTECT, `FSP_CMD_UNPROTECT: begin
                // [R16] [R21] hv on a9 and oe; caller protects all first
                hv_addr_en_ff <= 1'b1;
                hv_oe_en_ff <= 1'b1;
                flash_ce_n_ff <= 1'b0;
                flash_we_n_ff <= 1'b0;
                // [R20] unprotect select high
                flash_addr_ff[`FSP_ADDR_UNPROT_SEL] <= (cmd_op == `FSP_CMD_UNPROTECT);
                cnt_ff <= HV_CYC;
                state_ff <= ST_HV;
              end
              default: begin
                // [R17] verify: hv a9, select high, low bits low
                if (cmd_op == `FSP_CMD_VERIFY) begin
                  hv_addr_en_ff <= 1'b1;
                  flash_addr_ff[`FSP_ADDR_ID_SELECT] <= 1'b1;
                  flash_addr_ff[`FSP_ADDR_ID_LOW] <= 1'b0;
                  flash_addr_ff[`FSP_ADDR_UNPROT_SEL] <= 1'b0;
                end
                flash_dq_oe_ff <= 1'b0;
                flash_ce_n_ff <= 1'b0;
                flash_oe_n_ff <= 1'b0;
                cnt_ff <= READ_CYC + 13'h0002;
                state_ff <= ST_RD;
              end
            endcase
          end
        end
        ST_WR: begin
          if (cnt_done) begin
            // [R1] rising edge ends the cycle
            flash_we_n_ff <= 1'b1;
            cnt_ff <= WPULSE_CYC;
            state_ff <= ST_WR_GAP;
          end else begin
            cnt_ff <= cnt_ff - 13'h0001;
          end
        end
        ST_WR_GAP: begin
          flash_ce_n_ff <= 1'b1;
          flash_dq_oe_ff <= 1'b0;
          if (cnt_done) begin
            if (op_ff == `FSP_CMD_ERASE_ADD || op_ff == `FSP_CMD_POLL) begin
              // [R4] [R12] re-read after gap: window check or next poll
              flash_ce_n_ff <= 1'b0;
              flash_oe_n_ff <= 1'b0;
              cnt_ff <= READ_CYC + 13'h0002;
              state_ff <= ST_RD;
            end else begin
              rsp_code_ff <= (op_ff == `FSP_CMD_READ) ? `FSP_RES_FAIL : `FSP_RES_DONE;
              state_ff <= ST_RSP;
            end
          end else begin
            cnt_ff <= cnt_ff - 13'h0001;
          end
        end
        ST_HV: begin
          if (cnt_done) begin
            flash_we_n_ff <= 1'b1;
            cnt_ff <= WPULSE_CYC;
            state_ff <= ST_HV_END;
          end else begin
            cnt_ff <= cnt_ff - 13'h0001;
          end
        end
        ST_HV_END: begin
          if (cnt_done) begin
            hv_addr_en_ff <= 1'b0;
            hv_oe_en_ff <= 1'b0;
            flash_ce_n_ff <= 1'b1;
            rsp_code_ff <= `FSP_RES_DONE;
            state_ff <= ST_RSP;
          end else begin
            cnt_ff <= cnt_ff - 13'h0001;
          end
        end
        ST_RD: begin
          if (!cnt_done) begin
            cnt_ff <= cnt_ff - 13'h0001;
          end else begin
            // end the read so the next one is a fresh cycle
            flash_oe_n_ff <= 1'b1;
            flash_ce_n_ff <= 1'b1;
            rsp_rdata_ff <= rd;
            cnt_ff <= READ_CYC + 13'h0002;
            state_ff <= ST_RSP;
            rsp_code_ff <= `FSP_RES_DONE;
            if (op_ff == `FSP_CMD_ERASE_ADD) begin
              // [R12] high after means maybe rejected
              if (rd[`FSP_BIT_ERASE_WINDOW])
                rsp_code_ff <= `FSP_RES_REJECT;
            end else if (op_ff == `FSP_CMD_VERIFY) begin
              hv_addr_en_ff <= 1'b0;
            end else if (op_ff == `FSP_CMD_POLL) begin
              first_ff <= rd;
              nrd_ff <= nrd_ff + 2'h1;
              // [R4] need two reads to compare
              if (nrd_ff != 2'h0) begin
                if (!toggling(first_ff, rd)) begin
                  rsp_code_ff <= `FSP_RES_DONE;
                end else if (to_seen_ff) begin
                  // [R5] still toggling after timeout
                  rsp_code_ff <= `FSP_RES_FAIL;
                  state_ff <= ST_RST_WR;
                end else if (rd[`FSP_BIT_TIMEOUT]) begin
                  // [R5] timeout seen, test once more
                  to_seen_ff <= 1'b1;
                  state_ff <= ST_WR_GAP;
                end else begin
                  rsp_code_ff <= `FSP_RES_BUSY;
                end
              end else begin
                state_ff <= ST_WR_GAP;
              end
            end
          end
        end
        ST_RST_WR: begin
          // [R8] reset command back to array reads
          flash_dq_out_ff <= `FSP_RESET_CMD;
          flash_dq_oe_ff <= 1'b1;
          flash_ce_n_ff <= 1'b0;
          flash_we_n_ff <= 1'b0;
          op_ff <= `FSP_CMD_READ; // marks the reset write so fail code stays
          cnt_ff <= WPULSE_CYC;
          state_ff <= ST_WR;
        end
        ST_RSP: begin
          rsp_valid_ff <= 1'b1;
          state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end
endmodule // fsp_host
`default_nettype wire

// ==== verilog/fsp_regs.vh ====
// constants for the flash status and protection host controller
`ifndef FSP_REGS_VH
`define FSP_REGS_VH
// status bit positions on the data bus
`define FSP_BIT_DATA_ZERO 0
`define FSP_BIT_SECTOR_TOGGLE 2
`define FSP_BIT_ERASE_WINDOW 3
`define FSP_BIT_TIMEOUT 5
`define FSP_BIT_PROGRESS_TOGGLE 6
// address bit positions used in id and protect modes
`define FSP_ADDR_ID_LOW 0
`define FSP_ADDR_ID_SELECT 1
`define FSP_ADDR_UNPROT_SEL 6
// command codes
`define FSP_CMD_POLL 3'h0
`define FSP_CMD_READ 3'h1
`define FSP_CMD_WRITE 3'h2
`define FSP_CMD_PROTECT 3'h3
`define FSP_CMD_VERIFY 3'h4
`define FSP_CMD_UNPROTECT 3'h5
`define FSP_CMD_ERASE_ADD 3'h6
// result codes
`define FSP_RES_DONE 2'h0
`define FSP_RES_FAIL 2'h1
`define FSP_RES_BUSY 2'h2
`define FSP_RES_REJECT 2'h3
// bus timing: read access 120 ns, write pulse 60 ns, hv pulse 100 us
`define FSP_T_READ_NS 120
`define FSP_T_WPULSE_NS 60
`define FSP_T_HV_US 100
`define FSP_CLK_MHZ 50
// cycle counts rounded up to whole clocks, sized to the 13-bit counter
`define FSP_READ_CYC 13'h0006
`define FSP_WPULSE_CYC 13'h0003
`define FSP_HV_CYC 13'h1388
// reset command byte, returns the device to array reads
`define FSP_RESET_CMD 8'hf0
`endif

// ==== sim/fsp_host_checker.sv ====
// assertion checker on the flash host controller pins
`timescale 1ns/1ps
`default_nettype none
module fsp_host_checker (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // user side
  input wire logic cmd_valid,
  input wire logic cmd_ready_ff,
  input wire logic rsp_valid_ff,
  // flash side
  input wire logic [18:0] flash_addr_ff,
  input wire logic flash_dq_oe_ff,
  input wire logic flash_ce_n_ff,
  input wire logic flash_oe_n_ff,
  input wire logic flash_we_n_ff,
  input wire logic hv_addr_en_ff,
  input wire logic hv_oe_en_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wr_qual_a:
  assert property (!flash_we_n_ff && !hv_oe_en_ff |-> !flash_ce_n_ff && flash_oe_n_ff)
    else $error("write strobe without proper select");
  no_fight_a:
  assert property (!(flash_dq_oe_ff && !flash_oe_n_ff)) else $error("bus contention");
  we_width_a:
  assert property ($fell(flash_we_n_ff) |-> (!flash_we_n_ff)[*3]) else $error("short write pulse");
  prot_hv_a:
  assert property ($fell(flash_we_n_ff) && hv_oe_en_ff |-> hv_addr_en_ff)
    else $error("hv pulse without address hv");
  unprot_cs_a:
  assert property (!flash_we_n_ff && hv_oe_en_ff && flash_addr_ff[6] |-> !flash_ce_n_ff)
    else $error("unprotect without chip select");
  verify_addr_a:
  assert property (hv_addr_en_ff && !hv_oe_en_ff && !flash_oe_n_ff
    |-> flash_addr_ff[1] && !flash_addr_ff[0] && !flash_addr_ff[6]) else $error("bad verify address");
  one_req_a:
  assert property (cmd_valid && cmd_ready_ff |=> !cmd_ready_ff) else $error("ready held after take");
  idle_bus_a:
  assert property (cmd_ready_ff |-> flash_ce_n_ff && flash_we_n_ff && !hv_oe_en_ff)
    else $error("bus busy while idle");
  // main scenarios reached
  cover property ($fell(flash_we_n_ff) && hv_oe_en_ff);
  cover property (hv_addr_en_ff && !flash_oe_n_ff);
  cover property (rsp_valid_ff);
endmodule // fsp_host_checker
bind fsp_host fsp_host_checker chk (.*);
`default_nettype wire

// ==== sim/fsp_flash_model.sv ====
// behavioural flash device facing the host controller
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_model (
  // device pins
  input wire logic [18:0] addr,
  input wire logic [7:0] din,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic hv_a,
  input wire logic hv_oe,
  output logic [7:0] dq
);
  int tog_left = 0; // toggling reads left, set by bench
  logic q5 = 1'b0;
  logic tgl = 1'b0;
  logic prot = 1'b0;
  logic [7:0] last = 8'h00;
  logic [7:0] val;
  assign val = tog_left != 0 ? {1'b0, tgl, q5, 2'b01, tgl, 2'b00} :
    hv_a ? {7'h00, prot} : addr[7:0] ^ 8'h3c;
  // released bus shows inverse of last byte, never a stale value
  assign dq = (!ce_n && !oe_n && !hv_oe) ? val : ~last;
  // toggle bits flip per completed read
  always @(posedge oe_n) begin
    last <= val;
    if (tog_left != 0) begin
      tgl <= ~tgl;
      tog_left <= tog_left - 1;
    end
  end
  // write edge: never sets timeout; hv or reset
  always @(posedge we_n) begin
    if (hv_a && hv_oe) prot <= !addr[6];
    else if (!ce_n && oe_n && din == 8'hf0) tog_left <= 0;
  end
endmodule // fsp_flash_model
`default_nettype wire

// ==== sim/fsp_host_tb.sv ====
// self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
`include "fsp_regs.vh"
module fsp_host_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [2:0] cmd_op = 3'h0;
  logic [18:0] cmd_addr = 19'h00000;
  logic [7:0] cmd_wdata = 8'h00;
  logic cmd_ready_ff, rsp_valid_ff, flash_dq_oe_ff, flash_ce_n_ff, flash_oe_n_ff;
  logic flash_we_n_ff, hv_addr_en_ff, hv_oe_en_ff;
  logic [1:0] rsp_code_ff;
  logic [7:0] rsp_rdata_ff, flash_dq_out_ff, mdq, last;
  logic [18:0] flash_addr_ff, a;
  logic [15:0] lfsr = 16'd30001;
  logic [10:0] exp_q[$]; // mask, code, data
  int miscompares = 0;
  int samples_checked = 0;
  localparam logic [18:0] A = 19'h00078; // array byte 44, toggle bits set
  wire [7:0] flash_dq_in = flash_dq_oe_ff ? flash_dq_out_ff : mdq;
  fsp_host #(.HV_CYC(13'h0014)) DUT (.*);
  fsp_flash_model m (.addr(flash_addr_ff), .din(flash_dq_out_ff), .ce_n(flash_ce_n_ff),
    .oe_n(flash_oe_n_ff), .we_n(flash_we_n_ff), .hv_a(hv_addr_en_ff), .hv_oe(hv_oe_en_ff),
    .dq(mdq));
  initial forever #10 clk = ~clk;
  // ------------------------------------------------------------
  // drivers and checks
  // ------------------------------------------------------------
  task automatic chk(input logic [10:0] e, input logic [9:0] g);
    samples_checked++;
    if (e[10] ? (g[9:8] !== e[9:8]) : (g !== e[9:0])) begin
      miscompares++;
      $display("[ERR] %0t exp %h got %h", $time, e[9:0], g);
    end
  endtask
  task automatic req(input logic [2:0] op, input logic [18:0] ad, input logic [7:0] d,
    input logic [10:0] e);
    while (cmd_ready_ff !== 1'b1) @(negedge clk);
    exp_q.push_back(e);
    cmd_op = op;
    cmd_addr = ad;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask
  // set the device busy state; bench acts as the erase in flight
  task automatic busy(input int n, input logic t);
    m.tgl = 1'b0;
    m.tog_left = n;
    m.q5 = t;
  endtask
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // result watcher pops the oldest note
  always @(posedge clk) if (rsp_valid_ff === 1'b1) chk(exp_q.pop_front(),
    {rsp_code_ff, rsp_rdata_ff});
  // hang guard, about ten times the expected run
  initial begin
    #100000;
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      a = {lfsr, 3'h5};
      last = a[7:0] ^ 8'h3c;
      req(`FSP_CMD_READ, a, 8'h00, {1'b0, `FSP_RES_DONE, last});
      req(`FSP_CMD_WRITE, a, lfsr[7:0], {1'b0, `FSP_RES_DONE, last});
    end
    req(`FSP_CMD_POLL, A, 8'h00, {1'b0, `FSP_RES_DONE, 8'h44});
    // device state may only change once the previous poll has answered
    while (cmd_ready_ff !== 1'b1) @(negedge clk);
    busy(10, 1'b0);
    req(`FSP_CMD_POLL, A, 8'h00, {1'b0, `FSP_RES_BUSY, 8'h4c});
    req(`FSP_CMD_POLL, A, 8'h00, {1'b0, `FSP_RES_BUSY, 8'h4c});
    req(`FSP_CMD_ERASE_ADD, A, 8'h30, {1'b1, `FSP_RES_REJECT, 8'h00});
    while (cmd_ready_ff !== 1'b1) @(negedge clk);
    busy(10, 1'b1);
    req(`FSP_CMD_POLL, A, 8'h00, {1'b0, `FSP_RES_FAIL, 8'h28});
    req(`FSP_CMD_POLL, A, 8'h00, {1'b0, `FSP_RES_DONE, 8'h44});
    while (cmd_ready_ff !== 1'b1) @(negedge clk);
    busy(2, 1'b1);
    req(`FSP_CMD_POLL, A, 8'h00, {1'b0, `FSP_RES_DONE, 8'h44});
    req(`FSP_CMD_ERASE_ADD, A, 8'h30, {1'b0, `FSP_RES_DONE, 8'h44});
    req(`FSP_CMD_VERIFY, A, 8'h00, {1'b0, `FSP_RES_DONE, 8'h00});
    req(`FSP_CMD_PROTECT, A, 8'h00, {1'b0, `FSP_RES_DONE, 8'h00});
    req(`FSP_CMD_VERIFY, A, 8'h00, {1'b0, `FSP_RES_DONE, 8'h01});
    req(`FSP_CMD_UNPROTECT, A, 8'h00, {1'b0, `FSP_RES_DONE, 8'h01});
    req(`FSP_CMD_VERIFY, A, 8'h00, {1'b0, `FSP_RES_DONE, 8'h00});
    while (exp_q.size() != 0) @(negedge clk);
    give_verdict();
  end
endmodule // fsp_host_tb
`default_nettype wire
